// >>> rtl/pcsd_defs.svh
// Register indices, field positions and reset values of the chip select one decoder.
//
// Overview of operation
// R1 - Select mode 00 never asserts chip select one, and 00 is the reset value of the mode field.
// R2 - Select mode 01 asserts chip select one only while the address matches and the read strobe is active.
// R3 - Select mode 10 asserts chip select one only while the address matches and the write strobe is active.
// R4 - Select mode 11 drives chip select one from the address comparison alone, regardless of strobes.
// R5 - In I/O decode the start register is the lowest matching value of address bits 7 to 0.
// R6 - In memory decode the start register is the lowest matching value of address bits 15 to 8.
// R7 - In I/O decode the stop register is the last matching value of address bits 7 to 0.
// R8 - In memory decode the stop register is the last matching value of address bits 15 to 8.
// R9 - In I/O decode address bits 15 to 8 must equal the whole upper match register.
// R10 - In memory decode address bits 19 to 16 must equal the low nibble of the upper match register.
// R11 - The start, stop and upper match registers are read/write and reset to zero.
// R12 - The memory-or-I/O select bit picks I/O decode when 0, its reset value, and memory decode when 1.
// R13 - The range comparison is inclusive of both the start and the stop value.
// R14 - I/O decode matches only I/O bus cycles and memory decode matches only memory bus cycles.
`ifndef PCSD_DEFS_SVH
`define PCSD_DEFS_SVH

// Register indices; the APB byte address is four times the index.
`define PCSD_IDX_MODE 8'h24
`define PCSD_IDX_START 8'h25
`define PCSD_IDX_STOP 8'h26
`define PCSD_IDX_UPPER 8'h27
`define PCSD_IDX_STATUS 8'h2f

// Mode register fields.
`define PCSD_MODE_LSB 0
`define PCSD_MODE_MSB 1
`define PCSD_MIOB_BIT 7

// Status register fields.
`define PCSD_STAT_CS_BIT 0
`define PCSD_STAT_MATCH_BIT 1

// Reset values.
`define PCSD_RST_MODE 2'h0
`define PCSD_RST_MIOB 1'h0
`define PCSD_RST_START 8'h00
`define PCSD_RST_STOP 8'h00
`define PCSD_RST_UPPER 8'h00

`endif

// >>> rtl/pcsd_pkg.sv
// Types shared by the chip select one decoder.
package pcsd_pkg;

   // Encodings of the select mode field.
   typedef enum logic [1:0]
   {
      PCSD_MODE_OFF = 2'h0,
      PCSD_MODE_RD = 2'h1,
      PCSD_MODE_WR = 2'h2,
      PCSD_MODE_ADDR = 2'h3
   } pcsd_mode_e;

   // System bus pins, strobes already turned active high.
   typedef struct packed
   {
      logic [19:0] addr;
      logic is_mem;
      logic io_rd;
      logic io_wr;
      logic mem_rd;
      logic mem_wr;
   } pcsd_bus_s;

endpackage

// >>> rtl/pcsd_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ns
`default_nettype none

module pcsd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

// >>> rtl/pcsd_range_cmp.sv
// Inclusive window comparator: low <= value <= high.
`timescale 1ns/1ns
`default_nettype none

module pcsd_range_cmp #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] value_i,
   input wire logic [WIDTH-1:0] low_i,
   input wire logic [WIDTH-1:0] high_i,
   output logic inside_o
);

   // An inverted window (low above high) matches nothing.
   assign inside_o = (value_i >= low_i) && (value_i <= high_i);

endmodule

`default_nettype wire

// >>> rtl/pcsd_top.sv
// Chip select one address decoder with its APB register file.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pcsd_defs.svh"

module pcsd_top #(
   parameter int ADDR_W = 12
) (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [19:0] sys_addr_i,
   input wire logic sys_is_mem_i,
   input wire logic io_read_n_i,
   input wire logic io_write_n_i,
   input wire logic mem_read_n_i,
   input wire logic mem_write_n_i,
   output logic chip_select_one_n_o
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and state.

   pcsd_pkg::pcsd_mode_e select_mode_field_q;
   logic memory_or_io_select_q;
   logic [7:0] range_start_value_q;
   logic [7:0] range_stop_value_q;
   logic [7:0] upper_match_value_q;
   logic cs_n_q;
   logic match_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation.

   pcsd_pkg::pcsd_bus_s bus_raw;
   pcsd_pkg::pcsd_bus_s bus_s;

   // Strobes are inverted here so that the synchroniser resets to idle.
   assign bus_raw.addr = sys_addr_i;
   assign bus_raw.is_mem = sys_is_mem_i;
   assign bus_raw.io_rd = ~io_read_n_i;
   assign bus_raw.io_wr = ~io_write_n_i;
   assign bus_raw.mem_rd = ~mem_read_n_i;
   assign bus_raw.mem_wr = ~mem_write_n_i;

   pcsd_sync #(
      .WIDTH($bits(pcsd_pkg::pcsd_bus_s))
   ) u_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .async_i(bus_raw),
      .sync_o(bus_s)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode.

   wire io_decode;
   wire [7:0] range_field;
   wire [7:0] upper_field;
   wire [7:0] upper_ref;
   wire cycle_ok;
   wire in_range;
   wire upper_eq;
   wire addr_match;
   wire rd_strobe;
   wire wr_strobe;
   wire cs_active;

   // R12 decode type select
   assign io_decode = (memory_or_io_select_q == 1'b0);
   // R5 R6 R7 R8 window field
   assign range_field = io_decode ? bus_s.addr[7:0] : bus_s.addr[15:8];
   // R9 R10 upper field compare
   assign upper_field = io_decode ? bus_s.addr[15:8] : {4'h0, bus_s.addr[19:16]};
   assign upper_ref = io_decode ? upper_match_value_q : {4'h0, upper_match_value_q[3:0]};
   // R14 cycle type qualify
   assign cycle_ok = io_decode ? ~bus_s.is_mem : bus_s.is_mem;

   // R13 inclusive range compare
   pcsd_range_cmp #(
      .WIDTH(8)
   ) u_range (
      .value_i(range_field),
      .low_i(range_start_value_q),
      .high_i(range_stop_value_q),
      .inside_o(in_range)
   );

   // A one-value window serves as the equality test of the upper field.
   pcsd_range_cmp #(
      .WIDTH(8)
   ) u_upper (
      .value_i(upper_field),
      .low_i(upper_ref),
      .high_i(upper_ref),
      .inside_o(upper_eq)
   );

   assign addr_match = in_range && upper_eq && cycle_ok;

   // The strobe that qualifies must belong to the same cycle type as the decode.
   assign rd_strobe = io_decode ? bus_s.io_rd : bus_s.mem_rd;
   assign wr_strobe = io_decode ? bus_s.io_wr : bus_s.mem_wr;

   // R1 R2 R3 R4 mode select
   assign cs_active = (select_mode_field_q == pcsd_pkg::PCSD_MODE_RD) ? (addr_match && rd_strobe) :
                      (select_mode_field_q == pcsd_pkg::PCSD_MODE_WR) ? (addr_match && wr_strobe) :
                      (select_mode_field_q == pcsd_pkg::PCSD_MODE_ADDR) ? addr_match :
                      1'b0;

   // The chip select is registered so that the pin is glitch free; it trails the pins by three edges.
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         cs_n_q <= 1'b1;
         match_q <= 1'b0;
      end
      else
      begin
         cs_n_q <= ~cs_active;
         match_q <= addr_match;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB slave.

   wire apb_setup;
   wire apb_write;
   wire addr_ok;
   wire [7:0] reg_idx;
   wire hit_mode;
   wire hit_start;
   wire hit_stop;
   wire hit_upper;
   wire hit_status;
   wire mapped;
   wire [31:0] rdata_mux;
   wire wr_low_lane;

   assign apb_setup = psel_i && !penable_i;
   // Writes land only at the completing edge of the access phase.
   assign apb_write = psel_i && penable_i && pready_q && pwrite_i;
   assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[ADDR_W-1:10] == '0);
   assign reg_idx = paddr_i[9:2];
   assign hit_mode = addr_ok && (reg_idx == `PCSD_IDX_MODE);
   assign hit_start = addr_ok && (reg_idx == `PCSD_IDX_START);
   assign hit_stop = addr_ok && (reg_idx == `PCSD_IDX_STOP);
   assign hit_upper = addr_ok && (reg_idx == `PCSD_IDX_UPPER);
   assign hit_status = addr_ok && (reg_idx == `PCSD_IDX_STATUS);
   assign mapped = hit_mode || hit_start || hit_stop || hit_upper || hit_status;
   // Every register holds byte lane 0 only, so lanes 1 to 3 are ignored on write.
   assign wr_low_lane = apb_write && pstrb_i[0];

   assign rdata_mux = hit_mode ? {24'h0, memory_or_io_select_q, 5'h0, select_mode_field_q} :
                      hit_start ? {24'h0, range_start_value_q} :
                      hit_stop ? {24'h0, range_stop_value_q} :
                      hit_upper ? {24'h0, upper_match_value_q} :
                      hit_status ? {30'h0, match_q, ~cs_n_q} :
                      32'h0;

   // Zero wait states: ready is raised for the cycle that follows every setup cycle.
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup && !mapped;
         prdata_q <= apb_setup ? rdata_mux : 32'h0;
      end
   end

   // R11 register reset and write
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         select_mode_field_q <= pcsd_pkg::pcsd_mode_e'(`PCSD_RST_MODE);
         memory_or_io_select_q <= `PCSD_RST_MIOB;
         range_start_value_q <= `PCSD_RST_START;
         range_stop_value_q <= `PCSD_RST_STOP;
         upper_match_value_q <= `PCSD_RST_UPPER;
      end
      else if (wr_low_lane)
      begin
         if (hit_mode)
         begin
            select_mode_field_q <= pcsd_pkg::pcsd_mode_e'(pwdata_i[`PCSD_MODE_MSB:`PCSD_MODE_LSB]);
            memory_or_io_select_q <= pwdata_i[`PCSD_MIOB_BIT];
         end
         else if (hit_start)
            range_start_value_q <= pwdata_i[7:0];
         else if (hit_stop)
            range_stop_value_q <= pwdata_i[7:0];
         else if (hit_upper)
            upper_match_value_q <= pwdata_i[7:0];
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign chip_select_one_n_o = cs_n_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clock_i);
   endclocking

   default disable iff (!reset_n_i);

   sequence io_addr_hit_s;
      !memory_or_io_select_q && !bus_s.is_mem &&
      bus_s.addr[7:0] >= range_start_value_q && bus_s.addr[7:0] <= range_stop_value_q &&
      bus_s.addr[15:8] == upper_match_value_q;
   endsequence

   sequence mem_addr_hit_s;
      memory_or_io_select_q && bus_s.is_mem &&
      bus_s.addr[15:8] >= range_start_value_q && bus_s.addr[15:8] <= range_stop_value_q &&
      bus_s.addr[19:16] == upper_match_value_q[3:0];
   endsequence

   sequence apb_start_write_s;
      psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && hit_start;
   endsequence

   // R1 disabled mode
   mode_off_idle_a : assert property ( // R1
      select_mode_field_q == pcsd_pkg::PCSD_MODE_OFF |=> chip_select_one_n_o)
      else $error("chip select asserted with mode off");

   // R2 read qualified mode
   read_qual_a : assert property ( // R2
      select_mode_field_q == pcsd_pkg::PCSD_MODE_RD && !(addr_match && rd_strobe) |=> chip_select_one_n_o)
      else $error("read mode asserted without read strobe and match");

   // R3 write qualified mode
   write_qual_a : assert property ( // R3
      select_mode_field_q == pcsd_pkg::PCSD_MODE_WR && !(addr_match && wr_strobe) |=> chip_select_one_n_o)
      else $error("write mode asserted without write strobe and match");

   // R4 address only mode
   addr_only_a : assert property ( // R4
      select_mode_field_q == pcsd_pkg::PCSD_MODE_ADDR |=> chip_select_one_n_o == !$past(addr_match))
      else $error("address mode output differs from match");

   // R5 R7 R9 I/O window hit
   io_window_hit_a : assert property ( // R9
      select_mode_field_q == pcsd_pkg::PCSD_MODE_ADDR ##0 io_addr_hit_s |=> !chip_select_one_n_o)
      else $error("I/O window hit did not select");

   // R6 R8 R10 memory window hit
   mem_window_hit_a : assert property ( // R10
      select_mode_field_q == pcsd_pkg::PCSD_MODE_ADDR ##0 mem_addr_hit_s |=> !chip_select_one_n_o)
      else $error("memory window hit did not select");

   // R10 upper nibble mismatch
   mem_upper_miss_a : assert property ( // R10
      memory_or_io_select_q && bus_s.addr[19:16] != upper_match_value_q[3:0] |=> chip_select_one_n_o)
      else $error("memory decode selected with wrong upper nibble");

   // R13 below start refused
   below_start_a : assert property ( // R13
      range_field < range_start_value_q |=> chip_select_one_n_o)
      else $error("selected below start value");

   // R14 cycle type mismatch
   cycle_type_a : assert property ( // R14
      memory_or_io_select_q != bus_s.is_mem |=> chip_select_one_n_o && !match_q)
      else $error("selected on wrong cycle type");

   // R11 start register write
   start_write_a : assert property ( // R11
      apb_start_write_s |=> range_start_value_q == $past(pwdata_i[7:0]) && !pready_o)
      else $error("start register write lost");

   // R11 R12 reset values
   reset_zero_a : assert property ( // R11
      @(posedge clock_i) disable iff (1'b0)
      !reset_n_i |=> range_start_value_q == 8'h00 && range_stop_value_q == 8'h00 &&
         upper_match_value_q == 8'h00 && !memory_or_io_select_q &&
         select_mode_field_q == pcsd_pkg::PCSD_MODE_OFF && chip_select_one_n_o)
      else $error("register not zero after reset");

   // Setup then one-cycle ready, with ready low again on the cycle after it.
   apb_ready_a : assert property (
      apb_setup |=> pready_o ##1 !pready_o)
      else $error("APB ready not one cycle after setup");

   unmapped_err_a : assert property (
      apb_setup && !mapped |=> pslverr_o && pready_o && prdata_o == 32'h0)
      else $error("unmapped access not flagged");

   // R2 read strobe hit
   read_hit_a : assert property ( // R2
      select_mode_field_q == pcsd_pkg::PCSD_MODE_RD && addr_match && rd_strobe |=> !chip_select_one_n_o)
      else $error("read mode did not select on match with read strobe");

   // R3 write strobe hit
   write_hit_a : assert property ( // R3
      select_mode_field_q == pcsd_pkg::PCSD_MODE_WR && addr_match && wr_strobe |=> !chip_select_one_n_o)
      else $error("write mode did not select on match with write strobe");

   // R9 I/O upper mismatch
   io_upper_miss_a : assert property ( // R9
      !memory_or_io_select_q && bus_s.addr[15:8] != upper_match_value_q |=> chip_select_one_n_o)
      else $error("I/O decode selected with wrong upper byte");

   // R13 above stop refused
   above_stop_a : assert property ( // R13
      range_field > range_stop_value_q |=> chip_select_one_n_o)
      else $error("selected above stop value");

   // R11 start register read
   start_read_a : assert property ( // R11
      apb_setup && hit_start |=> prdata_o == {24'h0, $past(range_start_value_q)})
      else $error("start register read data wrong");

   // A write without byte lane 0 must leave the start, stop and upper match registers as they were.
   lane_skip_a : assert property (
      psel_i && penable_i && pready_o && pwrite_i && !pstrb_i[0] |=>
         $stable(range_start_value_q) && $stable(range_stop_value_q) && $stable(upper_match_value_q))
      else $error("write without lane 0 changed a register");

endmodule

`default_nettype wire

// >>> tb/pcsd_periph_model.sv
// Peripheral model on the system bus that counts how often chip select one selects it.
`timescale 1ns/1ns
`default_nettype none

module pcsd_periph_model (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic chip_select_n_i,
   output logic [15:0] select_cnt_o
);
   logic prev_n_q;

   // Falling edges are counted, not low cycles, so the total does not depend on decode latency.
   always_ff @(posedge clock_i)
   begin
      if (!reset_n_i)
      begin
         prev_n_q <= 1'b1;
         select_cnt_o <= 16'h0000;
      end
      else
      begin
         prev_n_q <= chip_select_n_i;
         if (prev_n_q && !chip_select_n_i)
            select_cnt_o <= select_cnt_o + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the chip select one decoder.
`timescale 1ns/1ns
`default_nettype none
`include "pcsd_defs.svh"

module tb;
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cs_n;
   logic [15:0] sel_cnt;
   pcsd_pkg::pcsd_bus_s sb = {20'hfffff, 5'h00};
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   int exp_sel = 0;

   pcsd_top i_pcsd_top (.clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sys_addr_i(sb.addr), .sys_is_mem_i(sb.is_mem),
      .io_read_n_i(~sb.io_rd), .io_write_n_i(~sb.io_wr), .mem_read_n_i(~sb.mem_rd),
      .mem_write_n_i(~sb.mem_wr), .chip_select_one_n_o(cs_n));

   pcsd_periph_model i_pcsd_periph_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .chip_select_n_i(cs_n), .select_cnt_o(sel_cnt));

   initial
   begin
      forever #20 clock_i = ~clock_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is sampled high, and only the bench timeout ends a wait.
   task automatic apb(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rdata, output logic err);
      psel <= 1'b1;
      pwrite <= is_wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1)
         @(posedge clock_i);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock_i);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h00, r, e);
      chk(r, exp);
      chk({31'h0, e}, {31'h0, exp_err});
   endtask

   // Strobes are {io_rd, io_wr, mem_rd, mem_wr}; pins go idle again afterwards.
   task automatic probe(input logic [19:0] a, input logic m, input logic [3:0] stb, input logic exp);
      sb <= {a, m, stb};
      repeat (4) @(posedge clock_i);
      chk({31'h0, cs_n}, {31'h0, ~exp});
      if (exp)
         exp_sel++;
      sb <= {20'hfffff, 5'h00};
      repeat (4) @(posedge clock_i);
   endtask

   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      rd(`PCSD_IDX_MODE, 32'h0, 1'b0);
      rd(`PCSD_IDX_START, 32'h0, 1'b0);
      rd(`PCSD_IDX_STOP, 32'h0, 1'b0);
      rd(`PCSD_IDX_UPPER, 32'h0, 1'b0);
      rd(8'h00, 32'h0, 1'b1);
      probe(20'h00000, 1'b0, 4'hc, 1'b0);
      wr(`PCSD_IDX_START, 8'h10);
      wr(`PCSD_IDX_STOP, 8'h20);
      wr(`PCSD_IDX_UPPER, 8'h03);
      for (int md = 0; md < 4; md++)
      begin
         wr(`PCSD_IDX_MODE, md[7:0]);
         probe(20'h00315, 1'b0, 4'h0, md == 3);
         probe(20'h00315, 1'b0, 4'h8, md == 1 || md == 3);
         probe(20'h00315, 1'b0, 4'h4, md >= 2);
         probe(20'h00315, 1'b0, 4'h2, md == 3);
      end
      probe(20'h0030f, 1'b0, 4'h0, 1'b0);
      probe(20'h00310, 1'b0, 4'h0, 1'b1);
      probe(20'h00320, 1'b0, 4'h0, 1'b1);
      probe(20'h00321, 1'b0, 4'h0, 1'b0);
      probe(20'h00415, 1'b0, 4'h0, 1'b0);
      probe(20'h00315, 1'b1, 4'h0, 1'b0);
      wr(`PCSD_IDX_UPPER, 8'hf5);
      wr(`PCSD_IDX_MODE, 8'hff);
      rd(`PCSD_IDX_MODE, 32'h83, 1'b0);
      rd(`PCSD_IDX_START, 32'h10, 1'b0);
      rd(`PCSD_IDX_STOP, 32'h20, 1'b0);
      rd(`PCSD_IDX_UPPER, 32'hf5, 1'b0);
      probe(20'h51000, 1'b1, 4'h0, 1'b1);
      probe(20'h50fff, 1'b1, 4'h0, 1'b0);
      probe(20'h520ff, 1'b1, 4'h0, 1'b1);
      probe(20'h52100, 1'b1, 4'h0, 1'b0);
      probe(20'h61000, 1'b1, 4'h0, 1'b0);
      probe(20'h51000, 1'b0, 4'h0, 1'b0);
      wr(`PCSD_IDX_MODE, 8'h81);
      probe(20'h51000, 1'b1, 4'h8, 1'b0);
      probe(20'h51000, 1'b1, 4'h2, 1'b1);
      wr(`PCSD_IDX_MODE, 8'h82);
      probe(20'h51000, 1'b1, 4'h1, 1'b1);
      probe(20'h51000, 1'b1, 4'h2, 1'b0);
      pstrb <= 4'he;
      wr(`PCSD_IDX_START, 8'h55);
      pstrb <= 4'hf;
      rd(`PCSD_IDX_START, 32'h10, 1'b0);
      sb <= {20'h51000, 1'b1, 4'h0};
      repeat (4) @(posedge clock_i);
      rd(`PCSD_IDX_STATUS, 32'h2, 1'b0);
      sb <= {20'hfffff, 5'h00};
      repeat (4) @(posedge clock_i);
      chk({16'h0000, sel_cnt}, 32'(exp_sel));
      // A second reset in mid-run must bring every register back to zero.
      reset_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(posedge clock_i);
      chk({31'h0, cs_n}, 32'h1);
      rd(`PCSD_IDX_MODE, 32'h0, 1'b0);
      rd(`PCSD_IDX_START, 32'h0, 1'b0);
      rd(`PCSD_IDX_STOP, 32'h0, 1'b0);
      rd(`PCSD_IDX_UPPER, 32'h0, 1'b0);
      close_out();
   end
endmodule
`default_nettype wire
